// ---- bench/host_model.sv ----
/* host bus model: drives chip select, strobes and write data.
   assumes the device samples its inputs on posedge clk. */
module host_model (
  input wire logic clk, // bus clock
  output logic cs_n, // chip select
  output logic rd_n, // read strobe
  output logic wr_n, // write strobe
  output logic [7:0] wdata // write data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {cs_n, rd_n, wr_n, wdata} = 11'h7ff;
  // all strobes low only when the caller asks
  task automatic access(input logic rd, input logic wr, input logic [7:0] v);
    @(posedge clk);
    {cs_n, rd_n, wr_n, wdata} <= {1'b0, rd, wr, v};
    @(posedge clk);
    // released data shows the inverse, never the stale byte
    {cs_n, rd_n, wr_n, wdata} <= {3'h7, ~v};
  endtask
endmodule

// ---- bench/testbench.sv ----
/* self-checking bench for the configuration register port.
   assumes host_model drives the bus and resetn acts as power-on. */
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import cfg_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic cs_n, rd_n, wr_n, sync_m, bw, clamp, test_mode, write_seen;
  logic [7:0] wdata, cfg;
  logic [6:0] win;
  op_t op;
  logic [6:0] win_tab [4] = '{7'h09, 7'h0f, 7'h2f, 7'h4f};
  logic [7:0] tcode [2] = '{8'ha0, 8'hc0};
  int n_mismatch = 0;
  int samples_checked = 0;
  always #25 clk = ~clk;
  host_model i_host (.clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .wdata(wdata));
  adc_config_register_port i_dut (.clk(clk), .resetn(resetn), .cs_n(cs_n),
    .rd_n(rd_n), .wr_n(wr_n), .wdata(wdata), .config_value(cfg), .op(op),
    .sync_trigger_mode(sync_m), .bus_width_select(bw), .unipolar_clamp(clamp),
    .sample_window_length(win), .test_mode(test_mode), .write_seen(write_seen));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic power_on();
    @(posedge clk);
    resetn <= 1'b0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    #1;
    check(cfg, 8'h10);
    check({test_mode, sync_m, bw, clamp, 1'b0, op}, 8'h40);
  endtask
  task automatic write_chk(input logic [7:0] v);
    i_host.access(1'b1, 1'b0, v);
    #1;
    check(cfg, v);
    check({7'h0, write_seen}, 8'h01);
    @(posedge clk);
    #1;
    check({7'h0, write_seen}, 8'h00);
  endtask
  initial begin
    logic [7:0] v;
    power_on();
    for (int i = 0; i < 8; i++) begin
      v = {i[2:0], 1'b0, i[0], i[1], i[1:0]};
      write_chk(v);
      check(8'(op), (i < 4) ? 8'(i) : 8'(OP_START));
      check({6'h0, clamp, bw}, {6'h0, i[1], i[0]});
      check({1'b0, win}, {1'b0, win_tab[i[1:0]]});
    end
    check({7'h0, test_mode}, 8'h00);
    write_chk(8'h13);
    check({sync_m, win}, 8'h80);
    i_host.access(1'b0, 1'b1, 8'h00);
    #1;
    check({write_seen, cfg[6:0]}, 8'h13);
    write_chk(8'h80);
    // code 100 with all strobes low has no function and must not lock
    i_host.access(1'b0, 1'b0, 8'h00);
    #1;
    check({test_mode, cfg[6:0]}, 8'h00);
    for (int j = 0; j < 2; j++) begin
      power_on();
      write_chk(tcode[j]);
      i_host.access(1'b0, 1'b0, 8'h00);
      #1;
      check({7'h0, test_mode}, 8'h01);
      write_chk(8'h00);
      check({7'h0, test_mode}, 8'h01);
    end
    finish_test();
  end
endmodule

// ---- logic/adc_config_register_port.sv ----
/*
  write-only configuration register of the converter, with command decode,
  locked test mode entry, and read-side isolation of the register.
  assumes strobes synchronous to clk; resetn is the power-on reset.
*/
module adc_config_register_port
  import cfg_pkg::*;
(
  input wire logic clk, // 20 MHz clock
  input wire logic resetn, // async power-on reset, active low
  input wire logic cs_n, // chip select, active low
  input wire logic rd_n, // read strobe, active low
  input wire logic wr_n, // write strobe, active low
  input wire logic [7:0] wdata, // host write data
  output logic [7:0] config_value, // current register contents
  output op_t op, // decoded command
  output logic sync_trigger_mode, // trigger mode bit
  output logic bus_width_select, // bus width bit
  output logic unipolar_clamp, // clamp bit
  output logic [6:0] sample_window_length, // window clocks, async mode
  output logic test_mode, // latched test mode
  output logic write_seen // pulse: one cycle after a write was taken
);
  logic [7:0] cfg_r, cfg_nxt;
  logic test_r, test_nxt;
  logic ws_r, ws_nxt;
  logic wr_act, test_hit;
  cfg_if cif();

  assign cif.cfg = cfg_r;
  cfg_decode u_dec (.c(cif));

  // cs+rd+wr all low is not a write; it is the test entry strobe
  assign wr_act = !cs_n && !wr_n && rd_n;
  assign test_hit = !cs_n && !wr_n && !rd_n
    && (cfg_r[CMD_HI:CMD_LO] == CMD_TEST_A || cfg_r[CMD_HI:CMD_LO] == CMD_TEST_B);

  always_comb begin
    cfg_nxt = cfg_r;
    test_nxt = test_r || test_hit;
    ws_nxt = 1'h0;
    if (wr_act) begin
      cfg_nxt = wdata;
      ws_nxt = 1'h1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_r <= CFG_RESET;
      test_r <= 1'h0;
      ws_r <= 1'h0;
    end else begin
      cfg_r <= cfg_nxt;
      test_r <= test_nxt;
      ws_r <= ws_nxt;
    end
  end

  // register is never routed to any read path; no data bus output exists
  assign config_value = cfg_r;
  assign op = cif.op;
  assign sync_trigger_mode = cfg_r[TRIG_BIT];
  assign bus_width_select = cfg_r[BUSW_BIT];
  assign unipolar_clamp = cfg_r[CLAMP_BIT];
  // window only meaningful in async mode; report zero otherwise
  assign sample_window_length = cfg_r[TRIG_BIT] ? 7'h00 : cif.window;
  assign test_mode = test_r;
  assign write_seen = ws_r;

  // bus side: every write lands, and nothing else moves the register
  AST_WRITE_LANDS: assert property (
    @(posedge clk) disable iff (!resetn)
    (!cs_n && !wr_n && rd_n)
    |=> (config_value == $past(wdata)))
    else $error("write not captured");
  AST_WRITE_PULSE: assert property (
    @(posedge clk) disable iff (!resetn)
    (!cs_n && !wr_n && rd_n)
    |=> write_seen)
    else $error("write pulse missing");
  AST_PULSE_ONLY_WRITE: assert property (
    @(posedge clk) disable iff (!resetn)
    !(!cs_n && !wr_n && rd_n)
    |=> !write_seen)
    else $error("write pulse without write");
  AST_HOLD_NO_WRITE: assert property (
    @(posedge clk) disable iff (!resetn)
    !(!cs_n && !wr_n && rd_n)
    |=> $stable(config_value))
    else $error("register changed without write");

  // read side: a read leaves no trace in the register or in the pulse
  AST_READ_NO_CHANGE: assert property (
    @(posedge clk) disable iff (!resetn)
    (!cs_n && !rd_n)
    |=> $stable(config_value))
    else $error("read disturbed register");
  AST_READ_NO_PULSE: assert property (
    @(posedge clk) disable iff (!resetn)
    (!cs_n && !rd_n)
    |=> !write_seen)
    else $error("read taken as write");

  // test entry needs both a reserved code and all three strobes low
  AST_TEST_ENTRY: assert property (
    @(posedge clk) disable iff (!resetn)
    (!cs_n && !rd_n && !wr_n && cfg_r[7:5] inside {3'h5, 3'h6})
    |=> test_mode)
    else $error("test mode not entered");
  AST_NO_FALSE_TEST: assert property (
    @(posedge clk) disable iff (!resetn)
    (!test_mode && !(!cs_n && !rd_n && !wr_n))
    |=> !test_mode)
    else $error("spurious test mode");
  AST_OTHER_CODES_NO_TEST: assert property (
    @(posedge clk) disable iff (!resetn)
    (!test_mode && !(cfg_r[7:5] inside {3'h5, 3'h6}))
    |=> !test_mode)
    else $error("test mode from plain code");
  AST_TEST_STICKY: assert property (
    @(posedge clk) disable iff (!resetn)
    test_mode
    |=> test_mode)
    else $error("test mode left");

  // field layout, held against the byte that was written
  AST_TRIG_FIELD: assert property (
    @(posedge clk) disable iff (!resetn)
    (!cs_n && !wr_n && rd_n)
    |=> (sync_trigger_mode == $past(wdata[4])))
    else $error("trigger bit misplaced");
  AST_FIELDS: assert property (
    @(posedge clk) disable iff (!resetn)
    (!cs_n && !wr_n && rd_n)
    |=> (bus_width_select == $past(wdata[3]))
    && (unipolar_clamp == $past(wdata[2])))
    else $error("field layout wrong");

  // command decode; every code maps to a defined operation
  AST_STANDBY_DECODE: assert property (
    @(posedge clk) disable iff (!resetn)
    cfg_r[7:5] == 3'h0
    |-> op == OP_STANDBY)
    else $error("standby decode wrong");
  AST_FULLCAL_DECODE: assert property (
    @(posedge clk) disable iff (!resetn)
    cfg_r[7:5] == 3'h1
    |-> op == OP_FULLCAL)
    else $error("calibration decode wrong");
  AST_AUTOZERO_DECODE: assert property (
    @(posedge clk) disable iff (!resetn)
    cfg_r[7:5] == 3'h2
    |-> op == OP_AUTOZERO)
    else $error("auto zero decode wrong");
  AST_IDLE_DECODE: assert property (
    @(posedge clk) disable iff (!resetn)
    cfg_r[7:5] == 3'h3
    |-> op == OP_IDLE)
    else $error("idle decode wrong");
  AST_START_DECODE: assert property (
    @(posedge clk) disable iff (!resetn)
    cfg_r[7]
    |-> op == OP_START)
    else $error("start decode wrong");
  AST_OP_DEFINED: assert property (
    @(posedge clk) disable iff (!resetn)
    op != OP_NONE)
    else $error("command left undecoded");
  AST_OP_HOLD: assert property (
    @(posedge clk) disable iff (!resetn)
    !(!cs_n && !wr_n && rd_n)
    |=> $stable(op))
    else $error("command changed without write");

  // sample window, async mode only; zero is reported in sync mode
  AST_WINDOW_9: assert property (
    @(posedge clk) disable iff (!resetn)
    (!cfg_r[4] && cfg_r[1:0] == 2'h0)
    |-> sample_window_length == 7'h09)
    else $error("window length wrong");
  AST_WINDOW_15: assert property (
    @(posedge clk) disable iff (!resetn)
    (!cfg_r[4] && cfg_r[1:0] == 2'h1)
    |-> sample_window_length == 7'h0f)
    else $error("window length wrong");
  AST_WINDOW: assert property (
    @(posedge clk) disable iff (!resetn)
    (!cfg_r[4] && cfg_r[1:0] == 2'h2)
    |-> sample_window_length == 7'h2f)
    else $error("window length wrong");
  AST_WINDOW_79: assert property (
    @(posedge clk) disable iff (!resetn)
    (!cfg_r[4] && cfg_r[1:0] == 2'h3)
    |-> sample_window_length == 7'h4f)
    else $error("window length wrong");
  AST_WINDOW_SYNC: assert property (
    @(posedge clk) disable iff (!resetn)
    cfg_r[4]
    |-> sample_window_length == 7'h00)
    else $error("window shown in sync mode");
  AST_WINDOW_HOLD: assert property (
    @(posedge clk) disable iff (!resetn)
    !(!cs_n && !wr_n && rd_n)
    |=> $stable(sample_window_length))
    else $error("window changed without write");

  COV_WRITE: cover property (@(posedge clk) disable iff (!resetn) write_seen);
  COV_READ: cover property (@(posedge clk) disable iff (!resetn) !cs_n && !rd_n && wr_n);
  COV_TEST: cover property (@(posedge clk) disable iff (!resetn) $rose(test_mode));
  COV_START: cover property (@(posedge clk) disable iff (!resetn) op == OP_START);
  COV_FULLCAL: cover property (@(posedge clk) disable iff (!resetn) op == OP_FULLCAL);
endmodule

// ---- logic/cfg_decode.sv ----
/*
  combinational decode of the command field and sample window field.
  assumes the register value is stable from flip-flops.
*/
module cfg_decode
  import cfg_pkg::*;
(
  cfg_if.dec c // decoded fields
);
  always_comb begin
    c.op = OP_NONE;
    if (c.cfg[CMD_HI]) begin
      c.op = OP_START;
    end else begin
      case (c.cfg[CMD_HI:CMD_LO])
        CMD_STANDBY: c.op = OP_STANDBY;
        CMD_FULLCAL: c.op = OP_FULLCAL;
        CMD_AUTOZERO: c.op = OP_AUTOZERO;
        CMD_IDLE: c.op = OP_IDLE;
        default: c.op = OP_NONE;
      endcase
    end
  end
  always_comb begin
    case (c.cfg[WIN_HI:WIN_LO])
      2'h0: c.window = WIN_CLK_0;
      2'h1: c.window = WIN_CLK_1;
      2'h2: c.window = WIN_CLK_2;
      default: c.window = WIN_CLK_3;
    endcase
  end
endmodule

// ---- logic/cfg_if.sv ----
/*
  carries the register value to the decoder and the decoded fields back.
  assumes both ends share clk.
*/
interface cfg_if;
  import cfg_pkg::*;
  logic [7:0] cfg;
  op_t op;
  logic [6:0] window;
  modport src(output cfg, input op, input window);
  modport dec(input cfg, output op, output window);
endinterface

// ---- logic/cfg_pkg.sv ----
/*
  constants for the converter configuration register port: field layout,
  reset value, command codes and sample window lengths.
  assumes a single 20 MHz clock domain.
*/
package cfg_pkg;
  localparam int CFG_W = 8;
  localparam logic [7:0] CFG_RESET = 8'h10;
  localparam int CMD_HI = 7;
  localparam int CMD_LO = 5;
  localparam int TRIG_BIT = 4;
  localparam int BUSW_BIT = 3;
  localparam int CLAMP_BIT = 2;
  localparam int WIN_HI = 1;
  localparam int WIN_LO = 0;
  localparam logic [2:0] CMD_STANDBY = 3'h0;
  localparam logic [2:0] CMD_FULLCAL = 3'h1;
  localparam logic [2:0] CMD_AUTOZERO = 3'h2;
  localparam logic [2:0] CMD_IDLE = 3'h3;
  localparam logic [2:0] CMD_TEST_A = 3'h5;
  localparam logic [2:0] CMD_TEST_B = 3'h6;
  localparam logic [6:0] WIN_CLK_0 = 7'h09;
  localparam logic [6:0] WIN_CLK_1 = 7'h0f;
  localparam logic [6:0] WIN_CLK_2 = 7'h2f;
  localparam logic [6:0] WIN_CLK_3 = 7'h4f;
  typedef enum logic [2:0] {
    OP_STANDBY, OP_FULLCAL, OP_AUTOZERO, OP_IDLE, OP_START, OP_NONE
  } op_t;
endpackage
